/* rtl/cia_arbiter.sv */
// Three-level interrupt arbiter with register port and CPU handshake
`timescale 1ns/1ps
module cia_arbiter #(
   parameter int         N           = cia_pkg::NUM_VEC,
   parameter logic [N-1:0] NMI_LINES = '0,
   parameter int         FLASH_KB    = 4
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   // Register port
   input  wire logic [1:0]    reg_addr_i,
   input  wire logic [7:0]    reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic [7:0]         reg_rdata_o,
   // Protection key seen and instruction retire strobe
   input  wire logic          key_written_i,
   input  wire logic          instr_done_i,
   // Requests from peripherals and per-line enables
   input  wire logic [N-1:0]  irq_i,
   input  wire logic [N-1:0]  nmi_enable_i,
   input  wire logic          global_ie_i,
   // CPU handshake
   output logic               ack_valid_o,
   input  wire logic          ack_ready_i,
   output cia_pkg::cia_ack_t  ack_o,
   input  wire logic          return_from_interrupt_i
);
   logic [7:0]   ctrl_r;
   logic [7:0]   last_r;
   logic [7:0]   high_r;
   logic         nmi_act_r;
   logic         high_act_r;
   logic         norm_act_r;
   logic [2:0]   unlock_r;
   logic         gap_r;
   logic [7:0]   rdata_r;
   logic [N-1:0] nmi_req;
   logic [N-1:0] norm_req;
   logic         high_req;
   logic         nmi_any;
   logic         norm_any;
   logic [7:0]   nmi_idx;
   logic [7:0]   norm_idx;
   logic         take_nmi;
   logic         take_high;
   logic         take_norm;
   logic         accept;
   logic         rotate;
   logic [7:0]   vec_nxt;
   logic [1:0]   lvl_nxt;
   logic         rr_seen_r;

   assign rotate = ctrl_r[cia_pkg::BIT_ROTATE];

   assign nmi_req = irq_i & NMI_LINES & nmi_enable_i;

   always_comb begin
      norm_req = irq_i & ~NMI_LINES;
      high_req = 1'b0;
      if (high_r != cia_pkg::HIGH_NONE && int'(high_r) < N) begin
         high_req = norm_req[high_r[4:0]];
         norm_req[high_r[4:0]] = 1'b0;
      end
   end

   cia_pick #(
      .N        (N)
   ) u_pick_nmi (
      .req_i    (nmi_req),
      .rotate_i (1'b0),
      .last_i   (8'h00),
      .any_o    (nmi_any),
      .idx_o    (nmi_idx)
   );

   cia_pick #(
      .N        (N)
   ) u_pick_norm (
      .req_i    (norm_req),
      .rotate_i (rotate && rr_seen_r),
      .last_i   (last_r),
      .any_o    (norm_any),
      .idx_o    (norm_idx)
   );

   // Selection by level; gap holds everything after a return or entry
   always_comb begin
      take_nmi  = !gap_r && !nmi_act_r && nmi_any;
      take_high = !gap_r && !nmi_act_r && !nmi_any && global_ie_i
                  && high_req && !high_act_r;
      take_norm = !gap_r && !nmi_act_r && !nmi_any && global_ie_i
                  && !(high_req && !high_act_r)
                  && norm_any && !high_act_r && !norm_act_r;
   end

   assign ack_valid_o = take_nmi || take_high || take_norm;
   assign accept      = ack_valid_o && ack_ready_i;

   always_comb begin
      if (take_nmi) begin
         lvl_nxt = 2'(cia_pkg::CIA_LVL_NMI);
         vec_nxt = ctrl_r[cia_pkg::BIT_COMPACT] ? cia_pkg::COMPACT_NMI
                                                : nmi_idx;
      end else if (take_high) begin
         lvl_nxt = 2'(cia_pkg::CIA_LVL_HIGH);
         vec_nxt = ctrl_r[cia_pkg::BIT_COMPACT] ? cia_pkg::COMPACT_HIGH
                                                : high_r;
      end else begin
         lvl_nxt = 2'(cia_pkg::CIA_LVL_NORMAL);
         vec_nxt = ctrl_r[cia_pkg::BIT_COMPACT] ? cia_pkg::COMPACT_NORMAL
                                                : norm_idx;
      end
   end

   always_comb begin
      ack_o.vector    = vec_nxt;
      ack_o.level     = lvl_nxt;
      ack_o.base_boot = ctrl_r[cia_pkg::BIT_VEC_BASE];
      ack_o.jump_cycles = (FLASH_KB <= cia_pkg::SMALL_MEM_KB)
                          ? cia_pkg::JUMP_CYC_SMALL
                          : cia_pkg::JUMP_CYC_LARGE;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         unlock_r <= 3'h0;
      end else if (key_written_i) begin
         unlock_r <= cia_pkg::UNLOCK_W;
      end else if (reg_wr_i && reg_addr_i == cia_pkg::OFF_CTRL) begin
         unlock_r <= 3'h0;
      end else if (instr_done_i && unlock_r != 3'h0) begin
         unlock_r <= unlock_r - 3'h1;
      end
   end

   // Control register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ctrl_r <= cia_pkg::CTRL_RESET;
      end else if (reg_wr_i && reg_addr_i == cia_pkg::OFF_CTRL) begin
         ctrl_r[cia_pkg::BIT_ROTATE] <= reg_wdata_i[cia_pkg::BIT_ROTATE];
         if (unlock_r != 3'h0) begin
            ctrl_r[cia_pkg::BIT_VEC_BASE] <=
               reg_wdata_i[cia_pkg::BIT_VEC_BASE];
            ctrl_r[cia_pkg::BIT_COMPACT] <=
               reg_wdata_i[cia_pkg::BIT_COMPACT];
         end
      end
   end

   // High vector select register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         high_r <= cia_pkg::VEC_RESET;
      end else if (reg_wr_i && reg_addr_i == cia_pkg::OFF_HIGH_VEC) begin
         high_r <= reg_wdata_i;
      end
   end

   // Fixed order until first load
   // A reset value of zero would otherwise push vector 0 to the back
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rr_seen_r <= 1'b0;
      end else if ((accept && take_norm && rotate) ||
                   (reg_wr_i && reg_addr_i == cia_pkg::OFF_LAST_NORMAL)) begin
         rr_seen_r <= 1'b1;
      end
   end

   // Last normal vector; hardware load beats software write
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         last_r <= cia_pkg::VEC_RESET;
      end else if (accept && take_norm && rotate) begin
         last_r <= norm_idx;
      end else if (reg_wr_i && reg_addr_i == cia_pkg::OFF_LAST_NORMAL) begin
         last_r <= reg_wdata_i;
      end
   end

   // Executing-level flags; entry set wins over a return in one cycle
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         nmi_act_r  <= 1'b0;
         high_act_r <= 1'b0;
         norm_act_r <= 1'b0;
      end else begin
         if (return_from_interrupt_i) begin
            if (nmi_act_r) begin
               nmi_act_r <= 1'b0;
            end else if (high_act_r) begin
               high_act_r <= 1'b0;
            end else begin
               norm_act_r <= 1'b0;
            end
         end
         if (accept && take_nmi) begin
            nmi_act_r <= 1'b1;
         end
         if (accept && take_high) begin
            high_act_r <= 1'b1;
         end
         if (accept && take_norm) begin
            norm_act_r <= 1'b1;
         end
      end
   end

   // One instruction must retire after entry or return
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         gap_r <= 1'b0;
      end else if (accept || return_from_interrupt_i) begin
         gap_r <= 1'b1;
      end else if (instr_done_i) begin
         gap_r <= 1'b0;
      end
   end

   // Read data one cycle after the strobe; no side effects
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_r <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            cia_pkg::OFF_CTRL:        rdata_r <= ctrl_r
                                       & (cia_pkg::CTRL_PROT_MASK | 8'h01);
            cia_pkg::OFF_STATUS:      rdata_r <= {nmi_act_r, 5'h00,
                                                  high_act_r, norm_act_r};
            cia_pkg::OFF_LAST_NORMAL: rdata_r <= last_r;
            cia_pkg::OFF_HIGH_VEC:    rdata_r <= high_r;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_r;

   // No global-enable output exists, so acknowledge cannot alter it
endmodule // cia_arbiter

/* rtl/cia_pkg.sv */
// Package of constants and types for the cpu interrupt arbiter
// Notes on behaviour
// - All sources outside the non-maskable set normal; one promoted via vector register
// - High level preempts normal; normal resumes after
// - Non-maskable ignores global enable, never alters it
// - Nothing acknowledged while non-maskable handler runs
// - Lowest vector wins among non-maskable requests
// - Non-maskable set fixed; line must be enabled
// - Fixed priority: lowest vector address wins
// - Rotating enable bit selects round-robin arbitration
// - Last acknowledged normal vector gets lowest priority
// - Compact table: vectors 1, 2, shared 3
// - Protected bits need key then write soon
// - Unkeyed protected write accepted but ignored
// - Rotating enable bit writable without unlock
// - Placement bit picks boot or application base
// - Status bit 7 marks non-maskable handler running
// - Status bit 1 marks high handler, survives preemption
// - Status bit 0 marks normal handler, survives preemption
// - Round-robin loads acknowledged vector into field
// - After reset lowest vector has top priority
// - High vector zero disables high level
// - Small memory uses two-cycle relative jump entries
// - One instruction between handlers before next request
// - Maskable acknowledge leaves global enable unchanged
package cia_pkg;
   localparam int          NUM_VEC         = 32;
   localparam int          VEC_W           = 8;
   localparam logic [1:0]  OFF_CTRL        = 2'h0;
   localparam logic [1:0]  OFF_STATUS      = 2'h1;
   localparam logic [1:0]  OFF_LAST_NORMAL = 2'h2;
   localparam logic [1:0]  OFF_HIGH_VEC    = 2'h3;
   localparam int          BIT_VEC_BASE    = 6;
   localparam int          BIT_COMPACT     = 5;
   localparam int          BIT_ROTATE      = 0;
   localparam int          BIT_NMI_ACT     = 7;
   localparam int          BIT_HIGH_ACT    = 1;
   localparam int          BIT_NORMAL_ACT  = 0;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  VEC_RESET       = 8'h00;
   localparam logic [7:0]  CTRL_PROT_MASK  = 8'h60;
   localparam logic [7:0]  HIGH_NONE       = 8'h00;
   localparam logic [7:0]  COMPACT_NMI     = 8'h01;
   localparam logic [7:0]  COMPACT_HIGH    = 8'h02;
   localparam logic [7:0]  COMPACT_NORMAL  = 8'h03;
   localparam int          UNLOCK_INSTRS   = 4;
   localparam logic [2:0]  UNLOCK_W        = 3'h4;
   localparam int          SMALL_MEM_KB    = 8;
   localparam logic [1:0]  JUMP_CYC_SMALL  = 2'h2;
   localparam logic [1:0]  JUMP_CYC_LARGE  = 2'h3;

   typedef enum logic [1:0] {
      CIA_LVL_NORMAL,
      CIA_LVL_HIGH,
      CIA_LVL_NMI
   } cia_level_t;

   // Acknowledge answer to the CPU core
   typedef struct packed {
      logic [7:0] vector;
      logic [1:0] level;
      logic       base_boot;
      logic [1:0] jump_cycles;
   } cia_ack_t;
endpackage : cia_pkg

/* rtl/cia_pick.sv */
// Lowest-index or rotating pick among pending request lines
`timescale 1ns/1ps
module cia_pick #(
   parameter int N = 32
) (
   // Requests
   input  wire logic [N-1:0] req_i,
   input  wire logic         rotate_i,
   input  wire logic [7:0]   last_i,
   // Result
   output logic              any_o,
   output logic [7:0]        idx_o
);
   logic [N-1:0] after_last;
   logic         found_hi;
   logic [7:0]   hi_idx;
   logic [7:0]   lo_idx;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         after_last[i] = rotate_i && (i > int'(last_i));
      end
   end

   // Search after the last winner first, then wrap to the bottom
   always_comb begin
      found_hi = 1'b0;
      hi_idx   = 8'h00;
      lo_idx   = 8'h00;
      any_o    = |req_i;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i] && after_last[i]) begin
            found_hi = 1'b1;
            hi_idx   = 8'(i);
         end
         if (req_i[i]) begin
            lo_idx = 8'(i);
         end
      end
      idx_o = found_hi ? hi_idx : lo_idx;
   end
endmodule // cia_pick

/* verif/cia_arbiter_properties.sv */
// Port checker for the interrupt arbiter
`timescale 1ns/1ps
module cia_arbiter_properties #(
   parameter int           N         = 32,
   parameter logic [N-1:0] NMI_LINES = '0,
   parameter int           FLASH_KB  = 4
) (
   // Clock and reset
   input wire logic              clk_i,
   input wire logic              nrst_i,
   // Register writes
   input wire logic [1:0]        reg_addr_i,
   input wire logic [7:0]        reg_wdata_i,
   input wire logic              reg_wr_i,
   // Requests
   input wire logic [N-1:0]      irq_i,
   input wire logic [N-1:0]      nmi_enable_i,
   input wire logic              global_ie_i,
   // CPU handshake
   input wire logic              ack_valid_o,
   input wire logic              ack_ready_i,
   input wire cia_pkg::cia_ack_t ack_o,
   input wire logic              return_from_interrupt_i,
   input wire logic              instr_done_i
);
   localparam logic [1:0] L_NMI = cia_pkg::CIA_LVL_NMI;
   localparam logic [1:0] L_HI  = cia_pkg::CIA_LVL_HIGH;
   logic         acc;
   logic         nmi_run_r;
   logic [7:0]   hv_r;
   logic         gap_r;
   logic [N-1:0] nmi_req;
   assign acc     = ack_valid_o && ack_ready_i;
   assign nmi_req = irq_i & nmi_enable_i & NMI_LINES;
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // High vector is never protected, so a shadow is exact
   always_ff @(posedge clk_i) begin
      if (!nrst_i) hv_r <= 8'h00;
      else if (reg_wr_i && reg_addr_i == cia_pkg::OFF_HIGH_VEC)
         hv_r <= reg_wdata_i;
   end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) nmi_run_r <= 1'b0;
      else if (acc && ack_o.level == L_NMI) nmi_run_r <= 1'b1;
      else if (return_from_interrupt_i) nmi_run_r <= 1'b0;
   end
   // Gap opens on entry or return, closes when an instruction retires
   always_ff @(posedge clk_i) begin
      if (!nrst_i) gap_r <= 1'b0;
      else if (acc || return_from_interrupt_i) gap_r <= 1'b1;
      else if (instr_done_i) gap_r <= 1'b0;
   end
   AST_NMI_EXCL: assert property (nmi_run_r |-> !ack_valid_o)
      else $error("offer while nmi handler runs");
   AST_GAP: assert property (gap_r |-> !ack_valid_o)
      else $error("offer without gap");
   AST_NMI_LOW: assert property (ack_valid_o && ack_o.level == L_NMI
      |-> (nmi_req & ~({N{1'b1}} << ack_o.vector)) == '0)
      else $error("nmi not lowest");
   AST_NMI_NO_IE: assert property (!global_ie_i && ack_valid_o
      |-> ack_o.level == L_NMI) else $error("maskable offer with ie low");
   AST_NMI_EN: assert property (ack_valid_o && ack_o.level == L_NMI
      |-> nmi_req != '0) else $error("nmi offer without enabled line");
   AST_JUMP: assert property (ack_valid_o |-> ack_o.jump_cycles ==
      (FLASH_KB <= cia_pkg::SMALL_MEM_KB ? cia_pkg::JUMP_CYC_SMALL
       : cia_pkg::JUMP_CYC_LARGE)) else $error("jump cycles wrong");
   AST_HIGH_OFF: assert property (ack_valid_o && hv_r == 8'h00
      |-> ack_o.level != L_HI) else $error("high offer while disabled");
   AST_HIGH_SRC: assert property (ack_valid_o && ack_o.level == L_HI
      |-> irq_i[hv_r]) else $error("high offer without its source");
   COV_NMI: cover property (acc && ack_o.level == L_NMI);
   COV_HIGH: cover property (acc && ack_o.level == L_HI);
   COV_NORMAL: cover property (acc && ack_o.level == 2'h0);
endmodule // cia_arbiter_properties

bind cia_arbiter cia_arbiter_properties #(.N(N), .NMI_LINES(NMI_LINES),
   .FLASH_KB(FLASH_KB)) cia_arbiter_properties_i (.clk_i(clk_i),
   .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .irq_i(irq_i), .nmi_enable_i(nmi_enable_i),
   .global_ie_i(global_ie_i), .ack_valid_o(ack_valid_o),
   .ack_ready_i(ack_ready_i), .ack_o(ack_o), .return_from_interrupt_i(return_from_interrupt_i),
   .instr_done_i(instr_done_i));

/* verif/cia_cpu_model.sv */
// Behavioural CPU core taking vectors and executing returns
`timescale 1ns/1ps
module cia_cpu_model (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Bench controls
   input  wire logic              stall_i,
   input  wire logic              ret_req_i,
   // Arbiter side
   input  wire logic              ack_valid_i,
   input  wire cia_pkg::cia_ack_t ack_i,
   output logic                   ack_ready_o,
   output logic                   instr_done_o,
   output logic                   return_from_interrupt_o,
   // Last offer taken and count
   output cia_pkg::cia_ack_t      taken_o,
   output logic [7:0]             n_taken_o
);
   logic [3:0] depth_r;
   logic       acc;
   // Ready ignores valid, so no combinational loop
   assign ack_ready_o = !stall_i;
   assign acc         = ack_valid_i && ack_ready_o;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) instr_done_o <= 1'b0;
      else instr_done_o <= !instr_done_o;
   end
   // return only from a running handler
   always_ff @(posedge clk_i) begin
      if (!nrst_i) return_from_interrupt_o <= 1'b0;
      else return_from_interrupt_o <= ret_req_i && depth_r != 4'h0;
   end
   // take offer on valid and ready
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         depth_r   <= 4'h0;
         n_taken_o <= 8'h00;
         taken_o   <= '0;
      end else begin
         depth_r <= depth_r + 4'(acc) - 4'(return_from_interrupt_o);
         if (acc) begin
            taken_o   <= ack_i;
            n_taken_o <= n_taken_o + 8'h01;
         end
      end
   end
endmodule // cia_cpu_model

/* verif/tb.sv */
// Self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] NMI_SET = 32'h0000_0006;
   logic              clk_i, nrst_i, reg_wr_i, reg_rd_i, key_written_i;
   logic              global_ie_i, stall, ret_req, ack_valid_o;
   logic              ack_ready_i, instr_done_i, return_from_interrupt_i;
   logic [1:0]        reg_addr_i;
   logic [7:0]        reg_wdata_i, reg_rdata_o, n_taken;
   logic [31:0]       irq_i, nmi_enable_i;
   cia_pkg::cia_ack_t ack_o, taken;
   int                bad_count, n_compared;
   cia_arbiter #(.NMI_LINES(NMI_SET)) cia_arbiter_i (.clk_i(clk_i),
      .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .key_written_i(key_written_i), .instr_done_i(instr_done_i),
      .irq_i(irq_i), .nmi_enable_i(nmi_enable_i), .global_ie_i(global_ie_i),
      .ack_valid_o(ack_valid_o), .ack_ready_i(ack_ready_i), .ack_o(ack_o),
      .return_from_interrupt_i(return_from_interrupt_i));
   cia_cpu_model cia_cpu_model_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .stall_i(stall), .ret_req_i(ret_req), .ack_valid_i(ack_valid_o),
      .ack_i(ack_o), .ack_ready_o(ack_ready_i), .instr_done_o(instr_done_i),
      .return_from_interrupt_o(return_from_interrupt_i), .taken_o(taken), .n_taken_o(n_taken));
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk("reg", {8'h00, reg_rdata_o}, {8'h00, exp});
      @(posedge clk_i);
   endtask
   task automatic key();
      key_written_i <= 1'b1;
      @(posedge clk_i);
      key_written_i <= 1'b0;
   endtask
   // Lets exactly one offer through, then stalls again
   task automatic take(input logic [7:0] v, input logic [1:0] l,
                       input logic b);
      logic [7:0] n0;
      n0 = n_taken;
      stall <= 1'b0;
      for (int i = 0; i < 40 && n_taken == n0; i++) @(posedge clk_i);
      stall <= 1'b1;
      @(posedge clk_i);
      chk("taken", 16'(n_taken), 16'(n0 + 8'h01));
      chk("ack", 16'(taken), 16'({v, l, b, cia_pkg::JUMP_CYC_SMALL}));
   endtask
   task automatic ret(input logic [7:0] st);
      ret_req <= 1'b1;
      @(posedge clk_i);
      ret_req <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(cia_pkg::OFF_STATUS, st);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Tests need fewer than two hundred cycles
   initial begin
      #200_000;
      bad_count++;
      wrap_up();
   end
   initial begin
      {nrst_i, reg_wr_i, reg_rd_i, key_written_i, ret_req} = 5'h00;
      {stall, global_ie_i, reg_addr_i, reg_wdata_i} = 12'h c00;
      {irq_i, nmi_enable_i} = 64'h0000_0000_0000_0000;
      bad_count = 0;
      n_compared = 0;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
      $display("test reset values done");
      irq_i <= 32'h0000_0220;
      take(8'h05, 2'h0, 1'b0);
      rd(cia_pkg::OFF_STATUS, 8'h01);
      wr(cia_pkg::OFF_HIGH_VEC, 8'h09);
      take(8'h09, 2'h1, 1'b0);
      rd(cia_pkg::OFF_STATUS, 8'h03);
      global_ie_i <= 1'b0;
      irq_i[1] <= 1'b1;
      stall <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk("count", 16'(n_taken), 16'h0002);
      nmi_enable_i <= NMI_SET;
      irq_i[2] <= 1'b1;
      take(8'h01, 2'h2, 1'b0);
      irq_i <= 32'h0000_0000;
      rd(cia_pkg::OFF_STATUS, 8'h83);
      ret(8'h03);
      ret(8'h01);
      ret(8'h00);
      $display("test nesting done");
      wr(cia_pkg::OFF_HIGH_VEC, 8'h00);
      wr(cia_pkg::OFF_CTRL, 8'h01);
      rd(cia_pkg::OFF_CTRL, 8'h01);
      global_ie_i <= 1'b1;
      irq_i <= 32'h0000_0210;
      take(8'h04, 2'h0, 1'b0);
      rd(cia_pkg::OFF_LAST_NORMAL, 8'h04);
      ret(8'h00);
      take(8'h09, 2'h0, 1'b0);
      ret(8'h00);
      take(8'h04, 2'h0, 1'b0);
      ret(8'h00);
      $display("test round robin done");
      irq_i <= 32'h0000_0000;
      wr(cia_pkg::OFF_CTRL, 8'h61);
      rd(cia_pkg::OFF_CTRL, 8'h01);
      key();
      wr(cia_pkg::OFF_CTRL, 8'h61);
      rd(cia_pkg::OFF_CTRL, 8'h61);
      key();
      repeat (12) @(posedge clk_i);
      wr(cia_pkg::OFF_CTRL, 8'h01);
      rd(cia_pkg::OFF_CTRL, 8'h61);
      irq_i <= 32'h0000_0080;
      take(cia_pkg::COMPACT_NORMAL, 2'h0, 1'b1);
      wr(cia_pkg::OFF_HIGH_VEC, 8'h09);
      irq_i <= 32'h0000_0280;
      take(cia_pkg::COMPACT_HIGH, 2'h1, 1'b1);
      irq_i <= 32'h0000_0282;
      take(cia_pkg::COMPACT_NMI, 2'h2, 1'b1);
      irq_i <= 32'h0000_0000;
      ret(8'h03);
      ret(8'h01);
      ret(8'h00);
      $display("test compact table done");
      wrap_up();
   end
endmodule // tb
